// ==== hdl/urx_defines.svh ====
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH
// register byte offsets (one aligned word each)
`define URX_OFF_DATA    4'h0
`define URX_OFF_STATUS  4'h4
`define URX_OFF_CTRLB   4'h8
`define URX_OFF_CTRLC   4'hC
// status field positions
`define URX_ST_PE       2
`define URX_ST_OVR      3
`define URX_ST_FE       4
`define URX_ST_RXC      7
// control b field positions
`define URX_CB_NINTH    1
`define URX_CB_RXEN     4
`define URX_CB_RXCIE    7
// control c field positions
`define URX_CC_CSZ0     1
`define URX_CC_STOP     3
`define URX_CC_PTYPE    4
`define URX_CC_PEN      5
`define URX_CC_U2X      6
`define URX_CC_CSZ2     7
// reset values
`define URX_CB_RESET    8'h00
`define URX_CC_RESET    8'h06
// sample timing in oversample ticks
`define URX_OS_NORMAL   5'h10
`define URX_OS_DOUBLE   5'h08
`define URX_VOTE_NORMAL 5'h08
`define URX_VOTE_DOUBLE 5'h04
`define URX_FIFO_DEPTH  2
`endif

// ==== hdl/urx_pkg.sv ====
package urx_pkg;
   // receive state machine
   typedef enum logic [1:0] {
      URX_IDLE,
      URX_START,
      URX_BITS
   } urx_state_t;
   // one stored frame: ninth bit, errors, data
   typedef struct packed {
      logic       fe;
      logic       ovr;
      logic       pe;
      logic       ninth;
      logic [7:0] data;
   } urx_entry_t;
endpackage

// ==== hdl/urx_fifo_if.sv ====
`timescale 1ns/10ps
// push/pop link between the receiver and its buffer
interface urx_fifo_if;
   logic               push;
   logic               pop;
   logic               flush;
   urx_pkg::urx_entry_t wdata;
   urx_pkg::urx_entry_t head;
   logic               full;
   logic               empty;
   modport ctrl (output push, output pop, output flush, output wdata,
                 input head, input full, input empty);
   modport mem  (input push, input pop, input flush, input wdata,
                 output head, output full, output empty);
endinterface

// ==== hdl/urx_fifo.sv ====
`timescale 1ns/10ps
`include "urx_defines.svh"
// two-entry receive buffer; head comes from a register
module urx_fifo (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // buffer link
   urx_fifo_if.mem  f
);
   urx_pkg::urx_entry_t mem_q [`URX_FIFO_DEPTH]; // storage
   logic                wp_q;                    // write pointer
   logic                rp_q;                    // read pointer
   logic [1:0]          cnt_q;                   // fill level
   logic                do_push;                 // accepted push
   logic                do_pop;                  // accepted pop

   assign do_push = f.push && (cnt_q != 2'h2 || f.pop);
   assign do_pop  = f.pop && (cnt_q != 2'h0);
   assign f.full  = (cnt_q == 2'h2);
   assign f.empty = (cnt_q == 2'h0);

   // storage write
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem_q[wp_q] <= f.wdata;
      end
   end

   // pointers and level; flush empties at once
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else if (f.flush) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (do_push) begin
            wp_q <= ~wp_q;
         end
         if (do_pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
      end
   end

   // registered head view, refreshed every cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         f.head <= '0;
      end else begin
         f.head <= mem_q[rp_q];
      end
   end
endmodule

// ==== hdl/urx_top.sv ====
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`include "urx_defines.svh"
// Operation
// - fifo holds ninth bit and error flags
// - rx complete reads one while unread
// - receiver disable flushes buffer immediately
// - interrupt requested while flag and enable
// - status writes never change error flags
// - error flags raise no interrupt
// - frame error shows first stop bit zero
// - only first stop bit is checked
// - overrun on start with buffer full and frame waiting
// - overrun clears on successful transfer
// - parity computed, compared, stored per frame
// - parity error zero when checking disabled
// - disable aborts frame, releases pin
// - sixteen or eight samples per bit
// - start vote on centre samples
// - high majority rejects start as noise
// - bits decided by three sample majority
// - zero stop bit sets frame error
// - shift bits, move frame on stop
// - enable gives pin to receiver
module urx_top (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // baud generator oversample tick
   input  wire logic        os_tick,
   // global interrupt enable
   input  wire logic        global_irq_en,
   // serial line
   input  wire logic        serial_input_pin,
   // outputs
   output logic             rx_irq,
   output logic             pin_override
);
   urx_fifo_if fif ();

   urx_pkg::urx_state_t st_q;        // receive state
   logic [7:0]  cb_q;                // control b
   logic [7:0]  cc_q;                // control c
   logic        ovr_pend_q;          // overrun seen, waits for next stored frame
   logic        held_q;              // finished frame waits in held_e_q
   urx_pkg::urx_entry_t held_e_q;    // that waiting frame
   logic [4:0]  smp_q;               // sample number within bit
   logic [3:0]  bit_q;               // bits received so far
   logic [9:0]  sh_q;                // shift register
   logic [1:0]  votes_q;             // high votes in window
   logic        pin_d1_q;            // previous pin sample
   logic        ack_q;               // bus answer phase
   logic        rx_en;               // receiver enabled
   logic        u2x;                 // double speed
   logic [2:0]  csz;                 // character size select
   logic [3:0]  ndata;               // data bits per frame
   logic [3:0]  nbits;               // data + parity + stop
   logic [4:0]  os_n;                // samples per bit
   logic [4:0]  vote0;               // first vote sample
   logic        in_window;           // centre sample now
   logic        last_smp;            // last centre sample of bit
   logic        voted;               // majority result
   logic        bus_req;             // new request
   logic        data_rd;             // data location read taken
   logic        frame_done;          // stop bit decided
   urx_pkg::urx_entry_t new_e;       // frame under assembly

   assign rx_en = cb_q[`URX_CB_RXEN];
   assign u2x   = cc_q[`URX_CC_U2X];
   assign csz   = {cc_q[`URX_CC_CSZ2], cc_q[`URX_CC_CSZ0+1], cc_q[`URX_CC_CSZ0]};
   assign ndata = (csz == 3'h7) ? 4'h9 : (csz[2] ? 4'h8 : 4'h5 + {1'b0, csz});
   assign nbits = ndata + {3'h0, cc_q[`URX_CC_PEN]} + 4'h1; // one stop only
   assign os_n  = u2x ? `URX_OS_DOUBLE : `URX_OS_NORMAL;
   assign vote0 = u2x ? `URX_VOTE_DOUBLE : `URX_VOTE_NORMAL;
   assign in_window = (smp_q >= vote0) && (smp_q <= vote0 + 5'h2);
   assign last_smp  = (smp_q == vote0 + 5'h2);
   // majority of three centre samples
   assign voted = (votes_q + {1'b0, serial_input_pin}) >= 2'h2;
   assign frame_done = os_tick && st_q == urx_pkg::URX_BITS && last_smp
                       && bit_q == nbits - 4'h1;

   // assemble frame entry from shift register
   always_comb begin
      logic [9:0] w;
      logic       par;
      w = sh_q >> (4'hB - nbits); // stop left out: nine data plus parity fill all ten
      par = ^(w & ((10'h001 << ndata) - 10'h001));
      new_e       = '0;
      new_e.data  = w[7:0];
      new_e.ninth = (csz == 3'h7) ? w[8] : 1'b0;
      new_e.fe    = ~voted;
      new_e.pe    = cc_q[`URX_CC_PEN] &&
                    ((par ^ w[ndata]) != cc_q[`URX_CC_PTYPE]);
      new_e.ovr   = 1'b0;
   end

   // receive sequencer; disable abandons frame at once
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q     <= urx_pkg::URX_IDLE;
         smp_q    <= 5'h00;
         bit_q    <= 4'h0;
         sh_q     <= 10'h000;
         votes_q  <= 2'h0;
         pin_d1_q <= 1'b1;
      end else if (!rx_en) begin
         st_q     <= urx_pkg::URX_IDLE;
         pin_d1_q <= 1'b1;
      end else if (os_tick) begin
         pin_d1_q <= serial_input_pin;
         unique case (st_q)
            urx_pkg::URX_IDLE: begin
               if (pin_d1_q && !serial_input_pin) begin
                  st_q    <= urx_pkg::URX_START; // first low sample is one
                  smp_q   <= 5'h02;
                  votes_q <= 2'h0;
               end
            end
            urx_pkg::URX_START: begin
               smp_q <= smp_q + 5'h01;
               if (in_window) begin
                  votes_q <= votes_q + {1'b0, serial_input_pin};
               end
               if (last_smp) begin
                  if (voted) begin
                     st_q <= urx_pkg::URX_IDLE; // noise spike
                  end
               end
               if (smp_q == os_n) begin
                  st_q    <= urx_pkg::URX_BITS; // synchronised
                  smp_q   <= 5'h01;
                  bit_q   <= 4'h0;
                  votes_q <= 2'h0;
               end
            end
            urx_pkg::URX_BITS: begin
               smp_q <= smp_q + 5'h01;
               if (in_window) begin
                  votes_q <= votes_q + {1'b0, serial_input_pin};
               end
               if (last_smp) begin
                  sh_q  <= {voted, sh_q[9:1]};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == nbits - 4'h1) begin
                     st_q <= urx_pkg::URX_IDLE; // next start may follow directly
                  end
               end
               if (smp_q == os_n) begin
                  smp_q   <= 5'h01;
                  votes_q <= 2'h0;
               end
            end
         endcase
      end
   end

   // buffer hand-off: frame waits in held_e_q until pushed to fifo
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         held_q     <= 1'b0;
         held_e_q   <= '0;
         ovr_pend_q <= 1'b0;
      end else if (!rx_en) begin
         held_q     <= 1'b0;
         ovr_pend_q <= 1'b0;
      end else begin
         if (os_tick && st_q == urx_pkg::URX_IDLE && pin_d1_q && !serial_input_pin
             && fif.full && held_q && !fif.push) begin
            ovr_pend_q <= 1'b1;
         end
         if (held_q && fif.push) begin
            held_q     <= 1'b0;
            ovr_pend_q <= 1'b0;
         end
         if (frame_done) begin
            held_q   <= 1'b1;
            held_e_q <= new_e;
         end
      end
   end

   // push waiting frame once there is room, carrying overrun
   always_comb begin
      fif.push        = held_q && (!fif.full || data_rd);
      fif.wdata       = held_e_q;
      fif.wdata.ovr   = ovr_pend_q;
      fif.pop         = data_rd;
      fif.flush       = !rx_en;
   end

   assign bus_req = (avs_read || avs_write) && !ack_q;
   assign data_rd = bus_req && avs_read && avs_address == `URX_OFF_DATA;

   // one wait state: answer on the cycle after the request
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q           <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_q           <= bus_req;
         avs_waitrequest <= !bus_req;
      end
   end

   // control writes; status writes leave error flags alone
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cb_q <= `URX_CB_RESET;
         cc_q <= `URX_CC_RESET;
      end else if (bus_req && avs_write && avs_byteenable[0]) begin
         if (avs_address == `URX_OFF_CTRLB) begin
            cb_q <= avs_writedata[7:0] & 8'hFD; // ninth bit is read-only
         end
         if (avs_address == `URX_OFF_CTRLC) begin
            cc_q <= avs_writedata[7:0];
         end
      end
   end

   // read mux; data masked to character size, unmapped reads zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_req && avs_read) begin
         avs_readdata <= 32'h0000_0000;
         unique case (avs_address)
            `URX_OFF_DATA: begin
               avs_readdata[7:0] <= fif.head.data & (8'hFF >> (4'h8 - (ndata > 4'h8 ?
                                    4'h8 : ndata)));
            end
            `URX_OFF_STATUS: begin
               avs_readdata[`URX_ST_RXC] <= !fif.empty;
               avs_readdata[`URX_ST_FE]  <= !fif.empty && fif.head.fe;
               avs_readdata[`URX_ST_OVR] <= !fif.empty && fif.head.ovr;
               avs_readdata[`URX_ST_PE]  <= !fif.empty && fif.head.pe;
            end
            `URX_OFF_CTRLB: begin
               avs_readdata[7:0] <= cb_q;
               avs_readdata[`URX_CB_NINTH] <= fif.head.ninth;
            end
            `URX_OFF_CTRLC: begin
               avs_readdata[7:0] <= cc_q;
            end
            default: begin
               avs_readdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // level interrupt; errors never feed it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rx_irq       <= 1'b0;
         pin_override <= 1'b0;
      end else begin
         rx_irq       <= cb_q[`URX_CB_RXCIE] && global_irq_en && !fif.empty && rx_en;
         pin_override <= rx_en;
      end
   end

   urx_fifo u_fifo (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .f       (fif.mem)
   );

   // checks
   property p_irq_level;
      @(posedge sys_clk) disable iff (!rstn)
         (cb_q[`URX_CB_RXCIE] && global_irq_en && !fif.empty && rx_en) |=> rx_irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised");
   property p_flush;
      @(posedge sys_clk) disable iff (!rstn) !rx_en |=> fif.empty;
   endproperty
   a_flush: assert property (p_flush) else $error("buffer not flushed");
   property p_pe_off;
      @(posedge sys_clk) disable iff (!rstn)
         frame_done && !cc_q[`URX_CC_PEN] |-> !new_e.pe;
   endproperty
   a_pe_off: assert property (p_pe_off) else $error("parity error while off");
   property p_fe;
      @(posedge sys_clk) disable iff (!rstn) frame_done |-> (new_e.fe == !voted);
   endproperty
   a_fe: assert property (p_fe) else $error("frame error wrong");
   property p_abort;
      @(posedge sys_clk) disable iff (!rstn) !rx_en |=> st_q == urx_pkg::URX_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("frame not abandoned");
   property p_pin;
      @(posedge sys_clk) disable iff (!rstn) ##1 (pin_override == $past(rx_en));
   endproperty
   a_pin: assert property (p_pin) else $error("pin override wrong");
   property p_noirq;
      @(posedge sys_clk) disable iff (!rstn) fif.empty |=> !rx_irq;
   endproperty
   a_noirq: assert property (p_noirq) else $error("irq without data");
   property p_ovr_clr;
      @(posedge sys_clk) disable iff (!rstn) held_q && fif.push && rx_en |=> !ovr_pend_q;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
   // a start meeting a full buffer and a waiting frame flags overrun
   property p_ovr_set;
      @(posedge sys_clk) disable iff (!rstn)
         rx_en && os_tick && st_q == urx_pkg::URX_IDLE && pin_d1_q && !serial_input_pin
         && fif.full && held_q && !fif.push |=> ovr_pend_q;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");
   // high majority on the start votes drops back to idle
   property p_noise;
      @(posedge sys_clk) disable iff (!rstn)
         rx_en && os_tick && st_q == urx_pkg::URX_START && last_smp && voted
         |=> st_q == urx_pkg::URX_IDLE;
   endproperty
   a_noise: assert property (p_noise) else $error("noise start not rejected");
   // status read shows unread data as seen at the taking edge
   property p_rxc_read;
      @(posedge sys_clk) disable iff (!rstn)
         bus_req && avs_read && avs_address == `URX_OFF_STATUS
         |=> avs_readdata[`URX_ST_RXC] != $past(fif.empty);
   endproperty
   a_rxc_read: assert property (p_rxc_read) else $error("rx complete misreported");
   // data read from a full buffer with nothing arriving frees a place
   property p_pop;
      @(posedge sys_clk) disable iff (!rstn)
         rx_en && data_rd && fif.full && !fif.push |=> !fif.full && !fif.empty;
   endproperty
   a_pop: assert property (p_pop) else $error("data read did not advance buffer");
   c_frame: cover property (@(posedge sys_clk) disable iff (!rstn) frame_done);
   c_ovr:   cover property (@(posedge sys_clk) disable iff (!rstn) ovr_pend_q);
   c_full:  cover property (@(posedge sys_clk) disable iff (!rstn) fif.full);
   c_noise: cover property (@(posedge sys_clk) disable iff (!rstn)
                            os_tick && st_q == urx_pkg::URX_START && last_smp && voted);
   c_perr:  cover property (@(posedge sys_clk) disable iff (!rstn) frame_done && new_e.pe);
endmodule

// ==== sim/urx_serial_tx.sv ====
`timescale 1ns/10ps
// remote serial sender, paced by the receiver's own oversample tick
module urx_serial_tx (
   // clock and pacing
   input wire logic sys_clk,
   input wire logic os_tick,
   // serial line, idle high as with a pull-up
   output logic     line
);
   // line rests at its idle level
   initial line = 1'b1;
   // hold one level for n oversample ticks
   task automatic hold(input logic v, input int n);
      line <= v;
      repeat (n) @(posedge sys_clk iff os_tick);
   endtask
   // one frame: start, data lsb first, optional parity, one stop bit
   // flip corrupts parity; stop low makes a framing fault
   task automatic send(input logic [8:0] v, input int nb, input logic pen, podd, flip,
                       input logic stop, input int spb);
      logic par;
      par = ^(v & ((9'h001 << nb) - 9'h001)) ^ podd ^ flip;
      hold(1'b0, spb);
      for (int i = 0; i < nb; i++)
         hold(v[i], spb);
      if (pen)
         hold(par, spb);
      hold(stop, spb);
      // after a low stop, one idle bit so the next start is a clean edge
      if (!stop)
         hold(1'b1, spb);
   endtask
endmodule

// ==== sim/uart_receive_path_tb_top.sv ====
`timescale 1ns/10ps
`include "urx_defines.svh"
// self-checking bench for the receive path
module uart_receive_path_tb_top;
   logic        sys_clk;          // system clock
   logic        rstn;             // async reset, active low
   logic [3:0]  avs_address;      // bus address
   logic        avs_read;         // read strobe
   logic        avs_write;        // write strobe
   logic [31:0] avs_writedata;    // write data
   logic [3:0]  avs_byteenable;   // byte lanes
   logic [31:0] avs_readdata;     // read data
   logic        avs_waitrequest;  // slave stall
   logic        os_tick;          // oversample pulse
   logic [1:0]  tick_cnt;         // four clocks per tick keeps frames short
   logic        global_irq_en;    // core interrupt gate
   logic        serial_input_pin; // line from the remote sender
   logic        rx_irq;           // interrupt request
   logic        pin_override;     // pin taken by receiver
   logic [31:0] exp_q[$];         // expected read values
   logic [31:0] msk_q[$];         // compared bit positions
   logic [8:0]  dv[0:4];          // random frame data
   int          miscompares;      // mismatch count
   int          n_checks;         // comparison count

   urx_top DUT (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
                .avs_byteenable, .avs_readdata, .avs_waitrequest, .os_tick, .global_irq_en,
                .serial_input_pin, .rx_irq, .pin_override);
   urx_serial_tx tx (.sys_clk, .os_tick, .line(serial_input_pin));

   // clock
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;
   // oversample tick divider
   always @(posedge sys_clk) begin
      tick_cnt <= tick_cnt + 2'h1;
      os_tick <= (tick_cnt == 2'h3);
   end
   // compare one value pair
   task automatic check(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // each completed read is judged against the oldest note
   always @(posedge sys_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
         check(avs_readdata & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // status word from its flags
   function automatic logic [31:0] stv(input logic rxc, fe, ovr, pe);
      stv = 32'h0;
      stv[`URX_ST_RXC] = rxc;
      stv[`URX_ST_FE] = fe;
      stv[`URX_ST_OVR] = ovr;
      stv[`URX_ST_PE] = pe;
   endfunction
   // wait for the slave answer; no cycle count assumed
   task automatic wait_ack;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
   endtask
   // bus read; an idle cycle follows so strobes never toggle twice at one edge
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // bus write of the low byte
   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {24'h0, v};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // level outputs, looked at mid-cycle once settled
   task automatic flags(input logic irq_e, pin_e);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check({31'h0, rx_irq}, {31'h0, irq_e});
      check({31'h0, pin_override}, {31'h0, pin_e});
      @(posedge sys_clk);
   endtask
   // one frame in, then status, data and the emptied status
   task automatic rx_one(input logic [8:0] v, input logic pen, podd, flip, stop,
                         input int spb);
      tx.send(v, 8, pen, podd, flip, stop, spb);
      rd(`URX_OFF_STATUS, stv(1'b1, ~stop, 1'b0, pen & flip), 32'h9C);
      rd(`URX_OFF_DATA, {24'h0, v[7:0]}, 32'hFF);
      rd(`URX_OFF_STATUS, stv(1'b0, 1'b0, 1'b0, 1'b0), 32'h9C);
   endtask
   // verdict, reached from the main sequence or the watchdog
   task automatic conclude;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog, well past the expected run of some 13000 cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      conclude();
   end
   // main sequence
   initial begin
      rstn = 1'b0;
      tick_cnt = 2'h0;
      os_tick = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      global_irq_en = 1'b0;
      miscompares = 0;
      n_checks = 0;
      void'($urandom(32'h9916));
      for (int i = 0; i < 5; i++)
         dv[i] = 9'($urandom);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      // reset values, an unmapped place, a write with its lane off
      flags(1'b0, 1'b0);
      rd(`URX_OFF_CTRLC, 32'h06, 32'hFF);
      rd(`URX_OFF_CTRLB, 32'h00, 32'h92);
      rd(4'h2, 32'h0, 32'hFFFFFFFF);
      wr(`URX_OFF_CTRLC, 8'h26, 4'h0);
      rd(`URX_OFF_CTRLC, 32'h06, 32'hFF);
      // enable with the interrupt on
      global_irq_en <= 1'b1;
      wr(`URX_OFF_CTRLB, 8'h90, 4'h1);
      flags(1'b0, 1'b1);
      // interrupt stands while a character is unread
      tx.send(dv[0], 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
      flags(1'b1, 1'b1);
      global_irq_en <= 1'b0;
      flags(1'b0, 1'b1);
      global_irq_en <= 1'b1;
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b0, 1'b0, 1'b0), 32'h9C);
      rd(`URX_OFF_DATA, {24'h0, dv[0][7:0]}, 32'hFF);
      flags(1'b0, 1'b1);
      // bad stop bit; status write must not touch it; no interrupt from it
      wr(`URX_OFF_CTRLB, 8'h10, 4'h1);
      tx.send(dv[1], 8, 1'b0, 1'b0, 1'b0, 1'b0, 16);
      wr(`URX_OFF_STATUS, 8'h00, 4'h1);
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b1, 1'b0, 1'b0), 32'h9C);
      flags(1'b0, 1'b1);
      rd(`URX_OFF_DATA, {24'h0, dv[1][7:0]}, 32'hFF);
      // stop count setting leaves single-stop frames clean
      wr(`URX_OFF_CTRLC, 8'h0E, 4'h1);
      rx_one(dv[2], 1'b0, 1'b0, 1'b0, 1'b1, 16);
      // even and odd parity, clean and corrupted
      for (int p = 0; p < 4; p++) begin
         wr(`URX_OFF_CTRLC, 8'h26 | (p[0] << 4), 4'h1);
         rx_one(9'($urandom), 1'b1, p[0], p[1], 1'b1, 16);
      end
      // double speed, eight ticks a bit, clean and bad stop
      wr(`URX_OFF_CTRLC, 8'h46, 4'h1);
      rx_one(dv[3], 1'b0, 1'b0, 1'b0, 1'b1, 8);
      rx_one(dv[4], 1'b0, 1'b0, 1'b0, 1'b0, 8);
      // nine-bit characters; ninth bit read before the data
      wr(`URX_OFF_CTRLC, 8'h86, 4'h1);
      tx.send({1'b1, dv[0][7:0]}, 9, 1'b0, 1'b0, 1'b0, 1'b1, 16);
      rd(`URX_OFF_CTRLB, 32'h12, 32'h92);
      rd(`URX_OFF_DATA, {24'h0, dv[0][7:0]}, 32'hFF);
      // nine bits with even parity, corrupted
      wr(`URX_OFF_CTRLC, 8'hA6, 4'h1);
      tx.send({1'b1, dv[1][7:0]}, 9, 1'b1, 1'b0, 1'b1, 1'b1, 16);
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b0, 1'b0, 1'b1), 32'h9C);
      rd(`URX_OFF_CTRLB, 32'h12, 32'h92);
      rd(`URX_OFF_DATA, {24'h0, dv[1][7:0]}, 32'hFF);
      // a low spike of seven samples is noise, then a real frame
      wr(`URX_OFF_CTRLC, 8'h06, 4'h1);
      tx.hold(1'b0, 7);
      tx.hold(1'b1, 64);
      rd(`URX_OFF_STATUS, stv(1'b0, 1'b0, 1'b0, 1'b0), 32'h9C);
      rx_one(dv[1], 1'b0, 1'b0, 1'b0, 1'b1, 16);
      // four frames unread: the last overwrites the waiting one
      for (int i = 0; i < 4; i++)
         tx.send(dv[i], 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b0, 1'b0, 1'b0), 32'h9C);
      rd(`URX_OFF_DATA, {24'h0, dv[0][7:0]}, 32'hFF);
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b0, 1'b0, 1'b0), 32'h9C);
      rd(`URX_OFF_DATA, {24'h0, dv[1][7:0]}, 32'hFF);
      rd(`URX_OFF_STATUS, stv(1'b1, 1'b0, 1'b1, 1'b0), 32'h9C);
      rd(`URX_OFF_DATA, {24'h0, dv[3][7:0]}, 32'hFF);
      rx_one(dv[4], 1'b0, 1'b0, 1'b0, 1'b1, 16);
      // disable in mid-frame with one character unread
      tx.send(dv[2], 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
      fork
         tx.send(dv[3], 8, 1'b0, 1'b0, 1'b0, 1'b1, 16);
         begin
            repeat (300) @(posedge sys_clk);
            wr(`URX_OFF_CTRLB, 8'h00, 4'h1);
         end
      join
      flags(1'b0, 1'b0);
      rd(`URX_OFF_STATUS, stv(1'b0, 1'b0, 1'b0, 1'b0), 32'h9C);
      wr(`URX_OFF_CTRLB, 8'h10, 4'h1);
      rx_one(dv[4], 1'b0, 1'b0, 1'b0, 1'b1, 16);
      conclude();
   end
endmodule
